// *** verification/bus_wait_state_generator_test.sv ***
/* Self-checking bench for the wait state generator.
   Assumes the partner model drives the wait pin. */
`timescale 1ns/1ps
`include "wait_gen_map.vh"
module bus_wait_state_generator_test;
    reg sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    reg cycle_start = 1'b0, fall_sample = 1'b0, dma_cycle = 1'b0;
    reg go = 1'b0;
    reg [3:0] reg_addr = 4'h0, hold = 4'h0;
    reg [7:0] reg_wdata = 8'h00, got, n;
    reg [2:0] cycle_kind = 3'h0, internal_wait_req = 3'h0;
    reg [19:0] seq_addr = 20'h0_0000;
    wire ext_wait_n, in_wait_state, enter_third_state, refresh_hold;
    wire [7:0] reg_rdata;
    wire [19:0] bus_addr;
    wire [3:0] bus_ctrl_n;
    integer err_count = 0, n_compared = 0, ticks = 0, i;
    bus_wait_state_generator bus_wait_state_generator_i (.sys_clk, .rst_n,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cycle_start,
        .fall_sample, .cycle_kind, .dma_cycle, .internal_wait_req,
        .ext_wait_n, .seq_addr, .seq_ctrl_n(4'ha), .in_wait_state,
        .enter_third_state, .refresh_hold, .bus_addr, .bus_ctrl_n);
    wait_partner wait_partner_i (.sys_clk, .go, .hold, .ext_wait_n);
    initial forever #50 sys_clk = ~sys_clk;
    // Address keeps moving so a frozen bus is visible
    always @(posedge sys_clk)
    begin
        seq_addr <= seq_addr + 20'h0_0001;
        ticks = ticks + 1;
        if (ticks == 3000)
        begin
            err_count = err_count + 1;
            report_and_stop;
        end
    end
    task check(input [7:0] seen, input [7:0] want);
    begin
        n_compared = n_compared + 1;
        if (seen !== want)
        begin
            err_count = err_count + 1;
            $display("mismatch at %0t: %h not %h", $time, seen, want);
        end
    end
    endtask
    task acc(input w, input [3:0] a, input [7:0] d);
    begin
        @(posedge sys_clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        got = reg_rdata;
    end
    endtask
    // Counts wait states over a window longer than any cycle
    task run(input [2:0] k);
    begin
        n = 8'h00;
        // Pin leads the cycle by the synchroniser's two stages
        @(posedge sys_clk);
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        @(posedge sys_clk);
        cycle_start <= 1'b1;
        cycle_kind <= k;
        @(posedge sys_clk);
        cycle_start <= 1'b0;
        fall_sample <= 1'b1;
        repeat (14)
        begin
            @(posedge sys_clk);
            n = n + {7'h00, in_wait_state === 1'b1};
        end
        fall_sample <= 1'b0;
    end
    endtask
    task t_reset;
    begin
        acc(1'b0, `WAIT_CTRL_ADDR, 8'h00);
        check(got, `WAIT_CTRL_RESET);
        acc(1'b0, 4'h7, 8'h00);
        check(got, 8'h00);
        run(`KIND_MEM);
        check(n, 8'h03);
        run(`KIND_EXT_IO);
        check(n, 8'h04);
    end
    endtask
    task t_fields;
    begin
        for (i = 0; i < 4; i = i + 1)
        begin
            dma_cycle <= i[0];
            acc(1'b1, `WAIT_CTRL_ADDR, {i[1:0], 6'h00});
            acc(1'b0, `WAIT_CTRL_ADDR, 8'h00);
            check(got, {i[1:0], 6'h00});
            run(`KIND_MEM);
            check(n, i);
            run(`KIND_ACK_VECTOR);
            check(n, i);
            acc(1'b1, `WAIT_CTRL_ADDR, {2'h0, i[1:0], 4'h0});
            run(`KIND_EXT_IO);
            check(n, i + 1);
            run(`KIND_IRQ0_ACK);
            check(n, i == 0 ? 2 : i + 3);
            acc(1'b0, `WAIT_STATUS_ADDR, 8'h00);
            check(got, {3'h0, i[0], 4'h0});
        end
    end
    endtask
    task t_internal;
    begin
        internal_wait_req <= 3'h4;
        run(`KIND_INT_IO_DATA);
        check(n, 8'h04);
        run(`KIND_INT_IO_CTRL);
        check(n, 8'h00);
    end
    endtask
    task t_ext;
    begin
        hold <= 4'h6;
        acc(1'b1, `WAIT_CTRL_ADDR, 8'h00);
        run(`KIND_MEM);
        check({7'h00, n >= 3 && n <= 6}, 8'h01);
        run(`KIND_INT_IO_CTRL);
        check(n, 8'h00);
        hold <= 4'h2;
        acc(1'b1, `WAIT_CTRL_ADDR, 8'hc0);
        run(`KIND_MEM);
        check(n, 8'h03);
    end
    endtask
    task t_abort;
    begin
        hold <= 4'h8;
        run(`KIND_INT_IO_CTRL);
        cycle_start <= 1'b1;
        cycle_kind <= `KIND_MEM;
        @(posedge sys_clk);
        cycle_start <= 1'b0;
        fall_sample <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        check({7'h00, in_wait_state}, 8'h00);
        fall_sample <= 1'b0;
        hold <= 4'h0;
        acc(1'b0, `WAIT_CTRL_ADDR, 8'h00);
        check(got, `WAIT_CTRL_RESET);
    end
    endtask
    task report_and_stop;
    begin
        $display("errors %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset;
        t_fields;
        t_internal;
        t_ext;
        t_abort;
        report_and_stop;
    end
endmodule

// *** verification/wait_gen_props.sv ***
/* Port checker for the wait state generator.
   Assumes binding to bus_wait_state_generator. */
`timescale 1ns/1ps
module wait_gen_props
(
    input wire sys_clk,
    input wire rst_n,
    input wire cycle_start,
    input wire [2:0] cycle_kind,
    input wire in_wait_state,
    input wire enter_third_state,
    input wire refresh_hold,
    input wire [19:0] bus_addr,
    input wire [3:0] bus_ctrl_n
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    refresh_off_a: assert property (refresh_hold == in_wait_state)
        else $error("refresh not held");
    bus_steady_a: assert property (in_wait_state && $past(in_wait_state)
        |-> $stable(bus_addr) && $stable(bus_ctrl_n)) else $error("bus moved");
    third_after_a: assert property ($fell(in_wait_state)
        |-> enter_third_state) else $error("no third state");
    third_pulse_a: assert property (enter_third_state
        |=> !enter_third_state) else $error("third too long");
    no_wait_third_a: assert property (enter_third_state
        |-> !in_wait_state) else $error("wait in third");
    io_min_a: assert property (cycle_start && cycle_kind == 3'h1
        |-> ##[1:3] in_wait_state) else $error("io without wait");
    ctrl_zero_a: assert property (cycle_start && cycle_kind == 3'h3
        |=> !in_wait_state [*3]) else $error("ctrl reg waited");
    reset_clear_a: assert property (disable iff (1'b0) !rst_n
        |=> !in_wait_state && bus_ctrl_n == 4'hf) else $error("reset kept");
    cover property (enter_third_state);
    cover property (in_wait_state [*3]);
    cover property (cycle_start && cycle_kind == 3'h4);
endmodule
bind bus_wait_state_generator wait_gen_props wait_gen_props_i (.sys_clk,
    .rst_n, .cycle_start, .cycle_kind, .in_wait_state, .enter_third_state,
    .refresh_hold, .bus_addr, .bus_ctrl_n);

// *** verification/wait_partner.sv ***
/* Slow peripheral driving the wait pin.
   Assumes go pulses with each bus cycle start. */
`timescale 1ns/1ps
module wait_partner
(
    input wire sys_clk,
    input wire go,
    input wire [3:0] hold,
    output reg ext_wait_n
);
    reg [3:0] left = 4'h0;
    initial ext_wait_n = 1'b1;
    // Pin moves only after rising edges
    always @(posedge sys_clk)
    begin
        left <= go ? hold : left - {3'h0, left != 4'h0};
        ext_wait_n <= go ? hold == 4'h0 : left < 4'h2;
    end
endmodule

// *** verilog/bus_wait_state_generator.v ***
/*
 * Bus wait state generator: stretches CPU and DMA bus cycles by the
 * larger of the external wait request (ignored for internal control register cycles) and a programmed count.
 * Assumes the bus sequencer reports each clock state and the cycle kind,
 * and runs on sys_clk; half-cycle sampling is modelled by a falling
 * edge enable from the sequencer.
 * Limitation: the internal data register count arrives ready made on
 * internal_wait_req; the peripherals' own synchronisation is not modelled.
 */
`timescale 1ns/1ps
`include "wait_gen_map.vh"

module bus_wait_state_generator
(
    input wire sys_clk,
    input wire rst_n,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire cycle_start,
    input wire fall_sample,
    input wire [2:0] cycle_kind,
    input wire dma_cycle,
    input wire [2:0] internal_wait_req,
    input wire ext_wait_n,
    input wire [19:0] seq_addr,
    input wire [3:0] seq_ctrl_n,
    output reg in_wait_state,
    output reg enter_third_state,
    output reg refresh_hold,
    output reg [19:0] bus_addr,
    output reg [3:0] bus_ctrl_n
);

    // ****************************************
    // Sequencer states
    // ****************************************
    localparam ST_IDLE = 2'b00;
    localparam ST_SECOND = 2'b01;
    localparam ST_WAIT = 2'b10;
    localparam ST_THIRD = 2'b11;

    reg [7:0] wait_control_register;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [2:0] prog_left;
    reg [2:0] next_prog_left;
    reg wait_meta;
    reg wait_sync;
    reg ext_req;
    reg [2:0] kind_hold;
    reg dma_hold;

    // ****************************************
    // Field decode
    // ****************************************
    wire [1:0] mem_wait_sel;
    wire [1:0] io_wait_sel;
    wire prog_pending;
    // Programmed waits still owed in this cycle
    assign prog_pending = (prog_left != 3'h0);
    assign mem_wait_sel = {wait_control_register[`MEM_SEL_HI_BIT],
                           wait_control_register[`MEM_SEL_LO_BIT]};
    assign io_wait_sel = {wait_control_register[`IO_SEL_HI_BIT],
                          wait_control_register[`IO_SEL_LO_BIT]};

    // ****************************************
    // Programmed count per cycle kind
    // ****************************************
    function [2:0] prog_count;
        input [2:0] kind;
        input [1:0] mem_sel;
        input [1:0] io_sel;
        input [2:0] int_req;
        begin
            case (kind)
                `KIND_MEM: prog_count = {1'b0, mem_sel};
                `KIND_ACK_VECTOR: prog_count = {1'b0, mem_sel};
                // Field plus one, so never below one wait
                `KIND_EXT_IO: prog_count = {1'b0, io_sel} + 3'h1;
                `KIND_INT_IO_DATA: prog_count = int_req;
                `KIND_INT_IO_CTRL: prog_count = 3'h0;
                `KIND_IRQ0_ACK:
                begin
                    // Fetch low acknowledge has its own table
                    case (io_sel)
                        2'b00: prog_count = `IRQ0_WAIT_00;
                        2'b01: prog_count = `IRQ0_WAIT_01;
                        2'b10: prog_count = `IRQ0_WAIT_10;
                        default: prog_count = `IRQ0_WAIT_11;
                    endcase
                end
                default: prog_count = {1'b0, mem_sel};
            endcase
        end
    endfunction

    // ****************************************
    // External wait qualification
    // ****************************************
    // Internal control registers finish in three clocks, so the pin
    // must not stretch them
    function ext_counts;
        input [2:0] kind;
        begin
            ext_counts = (kind != `KIND_INT_IO_CTRL);
        end
    endfunction

    // ****************************************
    // Register port
    // ****************************************
    always @(posedge sys_clk)
    begin
        if (!rst_n)
            wait_control_register <= `WAIT_CTRL_RESET;
        else if (reg_wr && reg_addr == `WAIT_CTRL_ADDR)
            wait_control_register <= reg_wdata;
    end

    // ****************************************
    // Register read port
    // ****************************************
    // Data stand for one cycle only; idle cycles read zero
    always @(posedge sys_clk)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `WAIT_CTRL_ADDR: reg_rdata <= wait_control_register;
                `WAIT_STATUS_ADDR: reg_rdata <= {3'h0, dma_hold,
                                                 prog_left, in_wait_state};
                default: reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

    // ****************************************
    // External wait synchroniser
    // ****************************************
    // Pin is asynchronous here; two stages even though the partner
    // aligns it to the rising edge
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            // Cleared stages mean no false wait right after reset
            wait_meta <= 1'b0;
            wait_sync <= 1'b0;
        end
        else
        begin
            wait_meta <= ~ext_wait_n;
            wait_sync <= wait_meta;
        end
    end

    // ****************************************
    // Wait sequencing
    // ****************************************
    always @*
    begin
        next_state = state;
        next_prog_left = prog_left;
        // Stale kind in idle is harmless: ext_req is unused there
        ext_req = fall_sample & wait_sync & ext_counts(kind_hold);
        case (state)
            ST_IDLE:
            begin
                if (cycle_start)
                begin
                    // Same path for CPU and DMA cycles
                    next_prog_left = prog_count(cycle_kind, mem_wait_sel,
                                                io_wait_sel,
                                                internal_wait_req);
                    next_state = ST_SECOND;
                end
            end
            ST_SECOND:
            begin
                if (fall_sample)
                begin
                    // OR of sources gives max of counts
                    if (ext_req || prog_pending)
                        next_state = ST_WAIT;
                    else
                        next_state = ST_THIRD;
                end
            end
            ST_WAIT:
            begin
                if (fall_sample)
                begin
                    if (prog_pending)
                        next_prog_left = prog_left - 3'h1;
                    // Another wait if either still asks
                    if (!(ext_req || prog_left > 3'h1))
                        next_state = ST_THIRD;
                end
            end
            ST_THIRD:
            begin
                // One third state, then ready for the next cycle
                next_state = ST_IDLE;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // Cycle state and capture
    // ****************************************
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            // Reset aborts any wait and drops the request
            state <= ST_IDLE;
            prog_left <= 3'h0;
            kind_hold <= `KIND_MEM;
            dma_hold <= 1'b0;
        end
        else
        begin
            state <= next_state;
            prog_left <= next_prog_left;
            if (state == ST_IDLE && cycle_start)
            begin
                kind_hold <= cycle_kind;
                dma_hold <= dma_cycle;
            end
        end
    end

    // ****************************************
    // State outputs
    // ****************************************
    // Taken from next_state so the outputs line up with the state
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            in_wait_state <= 1'b0;
            enter_third_state <= 1'b0;
            refresh_hold <= 1'b0;
        end
        else
        begin
            in_wait_state <= (next_state == ST_WAIT);
            enter_third_state <= (next_state == ST_THIRD) &&
                                 (state != ST_THIRD);
            // Refresh would disturb the frozen bus, so it waits too
            refresh_hold <= (next_state == ST_WAIT);
        end
    end

    // ****************************************
    // Bus freeze
    // ****************************************
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            bus_addr <= `BUS_ADDR_RESET;
            bus_ctrl_n <= `BUS_CTRL_RESET;
        end
        else if (next_state != ST_WAIT)
        begin
            // Freeze address and strobes while waiting
            bus_addr <= seq_addr;
            bus_ctrl_n <= seq_ctrl_n;
        end
    end

endmodule

// *** verilog/wait_gen_map.vh ***
/*
 * Constants for the bus wait state generator: register offsets, field
 * positions, reset values and wait counts.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef WAIT_GEN_MAP_VH
`define WAIT_GEN_MAP_VH

// ****************************************
// Register map
// ****************************************
`define WAIT_CTRL_ADDR 4'h0
`define WAIT_STATUS_ADDR 4'h1
`define WAIT_CTRL_RESET 8'hF0
`define BUS_ADDR_RESET 20'h0_0000
`define BUS_CTRL_RESET 4'hF
`define IO_SEL_LO_BIT 4
`define IO_SEL_HI_BIT 5
`define MEM_SEL_LO_BIT 6
`define MEM_SEL_HI_BIT 7

// ****************************************
// Cycle kinds
// ****************************************
`define KIND_MEM 3'h0
`define KIND_EXT_IO 3'h1
`define KIND_INT_IO_DATA 3'h2
`define KIND_INT_IO_CTRL 3'h3
`define KIND_IRQ0_ACK 3'h4
`define KIND_ACK_VECTOR 3'h5

// ****************************************
// Counts
// ****************************************
`define IRQ0_WAIT_00 3'h2
`define IRQ0_WAIT_01 3'h4
`define IRQ0_WAIT_10 3'h5
`define IRQ0_WAIT_11 3'h6

`endif
